/* File: rtl/tmr16_timer.sv */
// Register access over Wishbone and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module tmr16_timer (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic ce_i, // Clock enable, freezes all state
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write enable
  input wire logic [4:0] wb_adr_i, // Wishbone byte address
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  input wire logic count_input_pin_i, // External count or window pin
  input wire logic low_freq_step_i, // Low-frequency clock step
  input wire logic divider_chain_select_i, // Divider chain select
  input wire logic [1:0] power_mode_i, // Current power mode
  input wire logic stop_mode_i, // Chip stop mode level
  output logic compare_match_interrupt_o // One-cycle match pulse
);
  logic [7:0] counter_control_reg_r;
  logic [15:0] compare_value_reg_r;
  logic [7:0] low_buf_r;
  logic low_pend_r;
  logic [15:0] count_r;
  logic irq_r;
  logic ack_r;
  logic [31:0] rdata_r;
  logic pin_s1_r;
  logic pin_s2_r;
  logic pin_d_r;
  logic tick;
  logic req;
  logic wr_ctrl;
  logic wr_lo;
  logic wr_hi;
  logic run;
  logic [2:0] ck_sel;
  logic win_mode;
  logic event_mode;
  logic warm;
  logic pin_rise;
  logic pin_fall;
  logic [15:0] cnt_inc;
  logic hit_inc;
  logic hit_now;
  logic count_en;

  // Bus strobes, one access per acknowledged cycle
  assign req = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr_ctrl = req && wb_we_i && wb_sel_i[0] && (wb_adr_i == tmr16_pkg::ADDR_CTRL);
  assign wr_lo = req && wb_we_i && wb_sel_i[0] && (wb_adr_i == tmr16_pkg::ADDR_CMP_LO);
  assign wr_hi = req && wb_we_i && wb_sel_i[0] && (wb_adr_i == tmr16_pkg::ADDR_CMP_HI);

  // Control fields
  assign run = counter_control_reg_r[tmr16_pkg::CTRL_RUN_BIT];
  assign ck_sel = counter_control_reg_r[tmr16_pkg::CTRL_CK_LSB +: 3];
  assign win_mode = counter_control_reg_r[tmr16_pkg::CTRL_WIN_BIT];
  assign event_mode = !win_mode && (ck_sel == tmr16_pkg::CK_PIN);
  assign warm = !win_mode && (ck_sel == tmr16_pkg::CK_HF)
              && (power_mode_i == 2'(tmr16_pkg::TMR16_SECOND_SLOW_MODE));

  tmr16_prescaler u_presc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .lf_step_i(low_freq_step_i),
    .div_sel_i(divider_chain_select_i),
    .pmode_i(power_mode_i),
    .ck_sel_i(ck_sel),
    .tick_o(tick)
  );

  // Two-stage pin synchroniser and edge history
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
      pin_d_r <= 1'b0;
    end
    else if (ce_i)
    begin
      pin_s1_r <= count_input_pin_i;
      pin_s2_r <= pin_s1_r;
      pin_d_r <= pin_s2_r;
    end
  end

  assign pin_rise = pin_s2_r && !pin_d_r;
  assign pin_fall = !pin_s2_r && pin_d_r;

  // Control register; stop mode forces the run bit low
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      counter_control_reg_r <= tmr16_pkg::CTRL_RESET;
    else if (ce_i)
    begin
      if (wr_ctrl)
        counter_control_reg_r <= wb_dat_i[7:0] & tmr16_pkg::CTRL_WMASK;
      if (stop_mode_i)
        counter_control_reg_r[tmr16_pkg::CTRL_RUN_BIT] <= 1'b0; // [RL7]
    end
  end

  // Paired compare load: low byte parks, high byte commits
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      compare_value_reg_r <= tmr16_pkg::CMP_RESET;
      low_buf_r <= '0;
      low_pend_r <= 1'b0;
    end
    else if (ce_i)
    begin
      if (wr_lo)
      begin
        low_buf_r <= wb_dat_i[7:0]; // [RL2]
        low_pend_r <= 1'b1;
      end
      else if (wr_hi && (low_pend_r || warm))
      begin
        compare_value_reg_r <= {wb_dat_i[7:0], low_buf_r}; // [RL1] [RL9]
        low_pend_r <= 1'b0;
      end
      else if (wr_hi)
        low_pend_r <= 1'b0; // Lone high write dropped [RL1]
    end
  end

  // Match terms; warm-up compares the upper five bits only
  assign cnt_inc = count_r + 16'h0001;
  assign hit_inc = warm ? (cnt_inc[15:tmr16_pkg::WARM_LSB]
                           == compare_value_reg_r[15:tmr16_pkg::WARM_LSB]) // [RL9]
                        : (cnt_inc == compare_value_reg_r);
  assign hit_now = (count_r == compare_value_reg_r);
  assign count_en = tick && (!win_mode || pin_s2_r); // [RL14]

  // Up-counter for timer, window and event modes
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      count_r <= '0;
      irq_r <= 1'b0;
    end
    else if (ce_i)
    begin
      irq_r <= 1'b0;
      if (!run)
        count_r <= '0;
      else if (event_mode)
      begin
        if (pin_rise)
          count_r <= cnt_inc; // [RL11]
        else if (pin_fall && hit_now)
        begin
          count_r <= '0; // [RL12]
          irq_r <= 1'b1;
        end
      end
      else if (count_en)
      begin
        if (hit_inc)
        begin
          count_r <= '0; // [RL8] [RL14]
          irq_r <= 1'b1;
        end
        else
          count_r <= cnt_inc;
      end
    end
  end

  assign compare_match_interrupt_o = irq_r;

  // Bus answer one cycle after the request; unmapped reads zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_r <= 1'b0;
      rdata_r <= '0;
    end
    else if (ce_i)
    begin
      ack_r <= req;
      if (req)
      begin
        case (wb_adr_i)
          tmr16_pkg::ADDR_CTRL: rdata_r <= {24'h000000, counter_control_reg_r}; // [RL5]
          tmr16_pkg::ADDR_CMP_LO: rdata_r <= {24'h000000, compare_value_reg_r[7:0]};
          tmr16_pkg::ADDR_CMP_HI: rdata_r <= {24'h000000, compare_value_reg_r[15:8]};
          tmr16_pkg::ADDR_COUNT: rdata_r <= {16'h0000, count_r};
          tmr16_pkg::ADDR_STATUS: rdata_r <= {30'h00000000, run, low_pend_r};
          default: rdata_r <= '0;
        endcase
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence lone_high_s;
    ce_i && wr_hi && !low_pend_r && !warm;
  endsequence

  sequence low_then_idle_s;
    ce_i && wr_lo ##1 (ce_i && !wr_hi)[*2];
  endsequence

  lone_high_a: assert property (lone_high_s |=> $stable(compare_value_reg_r)) // [RL1]
    else $error("lone high byte write changed the compare value");
  low_hold_a: assert property (low_then_idle_s |-> $stable(compare_value_reg_r)) // [RL2]
    else $error("low byte write alone changed the compare value");
  pair_load_a: assert property (ce_i && wr_hi && low_pend_r |=>
                                compare_value_reg_r == {$past(wb_dat_i[7:0]), $past(low_buf_r)}) // [RL1]
    else $error("paired write did not load the low byte");
  stop_clear_a: assert property (ce_i && stop_mode_i |=> !run) // [RL7]
    else $error("run bit survived stop mode");
  timer_match_a: assert property (ce_i && run && !event_mode && count_en && hit_inc
                                  |=> compare_match_interrupt_o && count_r == 16'h0000) // [RL8]
    else $error("timer match did not interrupt and clear");
  warm_mask_a: assert property (ce_i && run && warm && count_en
                                && cnt_inc[15:11] == compare_value_reg_r[15:11]
                                |=> compare_match_interrupt_o) // [RL9]
    else $error("warm-up match on upper bits missed");
  event_rise_a: assert property (ce_i && run && event_mode && pin_rise
                                 |=> count_r == $past(count_r) + 16'h0001) // [RL11]
    else $error("event rising edge not counted");
  event_fall_a: assert property (ce_i && run && event_mode && pin_fall && hit_now
                                 |=> compare_match_interrupt_o ##1 !compare_match_interrupt_o) // [RL12]
    else $error("falling edge match did not give one pulse");
  event_norise_a: assert property (ce_i && run && event_mode && pin_rise
                                   |=> !compare_match_interrupt_o) // [RL12]
    else $error("event interrupt raised on a rising edge");
  window_hold_a: assert property (ce_i && run && win_mode && !pin_s2_r
                                  |=> $stable(count_r)) // [RL14]
    else $error("window counter moved while the pin was low");
  ctrl_read_a: assert property (ce_i && req && !wb_we_i && wb_adr_i == tmr16_pkg::ADDR_CTRL
                                |=> wb_ack_o && wb_dat_o[7:6] == 2'h0 && !wb_dat_o[1]) // [RL5]
    else $error("undefined control bits read nonzero");
endmodule // tmr16_timer

/* File: rtl/tmr16_pkg.sv */
// Functional notes
// RL1: Compare value loads low byte then high byte; a lone half write has no effect. Here a lone high write still loads during warm-up.
// RL2: Matching keeps the old compare value until the high byte completes the pair.
// RL3: Software changes mode and clock select only while the run bit is zero.
// RL4: Software loads a compare value above 1; upper five bits above 1 at warm-up.
// RL5: Control read bits 7, 6 and 1 are undefined; here they read as zero.
// RL6: Undivided high-frequency clock is chosen only for timer mode in second slow mode.
// RL7: Entering stop mode clears the run bit; software sets it again afterwards.
// RL8: Timer mode counts internal ticks; match raises interrupt, clears, keeps counting.
// RL9: High-frequency source in second slow mode matches upper 5 bits only.
// RL10: Timer mode on high or low clock can time oscillator warm-up intervals.
// RL11: Event mode counts count pin rising edges; match interrupts and clears.
// RL12: Event mode checks the match at the falling edge of the count pin.
// RL13: Count pin stays high and low at least two machine cycles each.
// RL14: Window mode counts internal ticks only while the pin is high.
// RL15: Window pin toggles much slower than the selected internal clock.
// RL16: Window mode is unusable in slow and sleep modes; stop before switching.
// RL17: Three-bit clock select picks divided clocks per divider chain and power mode.
package tmr16_pkg;
  // Register byte offsets
  localparam logic [4:0] ADDR_CTRL = 5'h00;
  localparam logic [4:0] ADDR_CMP_LO = 5'h04;
  localparam logic [4:0] ADDR_CMP_HI = 5'h08;
  localparam logic [4:0] ADDR_COUNT = 5'h0c;
  localparam logic [4:0] ADDR_STATUS = 5'h10;
  // Control field positions
  localparam int CTRL_RUN_BIT = 5;
  localparam int CTRL_CK_LSB = 2;
  localparam int CTRL_WIN_BIT = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'h3d;
  localparam logic [15:0] CMP_RESET = 16'hffff;
  // Source clock select codes
  localparam logic [2:0] CK_SLOWEST = 3'h0;
  localparam logic [2:0] CK_SLOW = 3'h1;
  localparam logic [2:0] CK_MID = 3'h2;
  localparam logic [2:0] CK_FAST = 3'h3;
  localparam logic [2:0] CK_LF = 3'h4;
  localparam logic [2:0] CK_LF_DIV = 3'h5;
  localparam logic [2:0] CK_HF = 3'h6;
  localparam logic [2:0] CK_PIN = 3'h7;
  // Divider masks on the high- and low-frequency chains
  localparam logic [22:0] HF_DIV23 = 23'h7fffff;
  localparam logic [22:0] HF_DIV13 = 23'h001fff;
  localparam logic [22:0] HF_DIV8 = 23'h0000ff;
  localparam logic [22:0] HF_DIV3 = 23'h000007;
  localparam logic [14:0] LF_DIV15 = 15'h7fff;
  localparam logic [14:0] LF_DIV10 = 15'h03ff;
  localparam logic [14:0] LF_DIV5 = 15'h001f;
  // Warm-up match ignores the lower compare bits
  localparam int WARM_LSB = 11;
  typedef enum logic [1:0] {TMR16_NORMAL, TMR16_FIRST_SLOW_MODE, TMR16_SECOND_SLOW_MODE, TMR16_SLEEP} tmr16_pmode_e;
endpackage

/* File: rtl/tmr16_prescaler.sv */
`timescale 1ns/1ps
module tmr16_prescaler (
  input wire logic clk_i, // System clock, high-frequency source
  input wire logic rst_i, // Synchronous reset
  input wire logic ce_i, // Clock enable
  input wire logic lf_step_i, // One-cycle low-frequency clock step
  input wire logic div_sel_i, // Divider chain select
  input wire logic [1:0] pmode_i, // Power mode
  input wire logic [2:0] ck_sel_i, // Source clock select
  output logic tick_o // One-cycle source tick
);
  logic [22:0] hf_cnt_r;
  logic [14:0] lf_cnt_r;
  logic slow;
  logic hf_ok;

  // Free-running high-frequency chain
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      hf_cnt_r <= '0;
    else if (ce_i)
      hf_cnt_r <= hf_cnt_r + 23'h000001;
  end

  // Low-frequency chain advances on each step
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      lf_cnt_r <= '0;
    else if (ce_i && lf_step_i)
      lf_cnt_r <= lf_cnt_r + 15'h0001;
  end

  assign slow = (pmode_i != 2'(tmr16_pkg::TMR16_NORMAL));
  assign hf_ok = ce_i && !slow;

  // Tick selection per code, divider chain and power mode
  always_comb
  begin
    tick_o = 1'b0;
    case (ck_sel_i)
      tmr16_pkg::CK_SLOWEST: // [RL17]
        if (slow || div_sel_i)
          tick_o = ce_i && lf_step_i && (lf_cnt_r == tmr16_pkg::LF_DIV15);
        else
          tick_o = hf_ok && (hf_cnt_r == tmr16_pkg::HF_DIV23);
      tmr16_pkg::CK_SLOW:
        if (slow || div_sel_i)
          tick_o = ce_i && lf_step_i && ((lf_cnt_r & tmr16_pkg::LF_DIV5) == tmr16_pkg::LF_DIV5);
        else
          tick_o = hf_ok && ((hf_cnt_r & tmr16_pkg::HF_DIV13) == tmr16_pkg::HF_DIV13);
      tmr16_pkg::CK_MID:
        tick_o = hf_ok && ((hf_cnt_r & tmr16_pkg::HF_DIV8) == tmr16_pkg::HF_DIV8);
      tmr16_pkg::CK_FAST:
        tick_o = hf_ok && ((hf_cnt_r & tmr16_pkg::HF_DIV3) == tmr16_pkg::HF_DIV3);
      tmr16_pkg::CK_LF: // Low clock kept in slow modes for warm-up [RL10]
        tick_o = ce_i && lf_step_i;
      tmr16_pkg::CK_LF_DIV:
        tick_o = hf_ok && lf_step_i && ((lf_cnt_r & tmr16_pkg::LF_DIV10) == tmr16_pkg::LF_DIV10);
      tmr16_pkg::CK_HF: // Undivided clock only in second slow mode [RL6]
        tick_o = ce_i && (pmode_i == 2'(tmr16_pkg::TMR16_SECOND_SLOW_MODE));
      default:
        tick_o = 1'b0;
    endcase
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  mid_slow_off_a: assert property ((ck_sel_i == tmr16_pkg::CK_MID) && slow |-> !tick_o) // [RL17]
    else $error("divided fast clock ticked in a slow mode");
endmodule // tmr16_prescaler

/* File: tb/tmr16_pin_src.sv */
`timescale 1ns/1ps
// Stand-in for the external event or window pulse source
module tmr16_pin_src (
  input wire logic clk_i, // System clock
  output logic pin_o // Count or window pin, idle low
);
  // Pin rests low until a phase is commanded
  initial pin_o = 1'b0;
  // Holds each level at least two cycles, slow against the ticks
  task automatic level(input logic v, input int n);
    pin_o <= v;
    repeat ((n < 2) ? 2 : n) @(posedge clk_i);
  endtask
endmodule // tmr16_pin_src

/* File: tb/test_sixteen_bit_timer_event_window_counter.sv */
`timescale 1ns/1ps
// Self-checking bench for the 16-bit timer and event counter
module test_sixteen_bit_timer_event_window_counter;
  logic clk_i;
  logic rst_i;
  logic req;
  logic we;
  logic stop;
  logic irq;
  logic ack;
  logic pin;
  logic [1:0] pmode;
  logic [4:0] adr;
  logic [31:0] dat;
  logic [31:0] rdat;
  logic [31:0] q;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;
  int irq_n = 0;
  int irq_t = 0;
  int irq_p = 0;
  int base;

  // Clock at 40 MHz
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // Cycle count, match pulse log and hang guard
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (irq === 1'b1)
    begin
      irq_n <= irq_n + 1;
      irq_p <= irq_t;
      irq_t <= cycles;
    end
    if (cycles == 20000)
    begin
      fail_count++;
      print_verdict();
    end
  end

  tmr16_timer dut_u (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(1'b1),
    .wb_cyc_i(req),
    .wb_stb_i(req),
    .wb_we_i(we),
    .wb_adr_i(adr),
    .wb_sel_i(4'h1),
    .wb_dat_i(dat),
    .wb_dat_o(rdat),
    .wb_ack_o(ack),
    .count_input_pin_i(pin),
    .low_freq_step_i(1'b0),
    .divider_chain_select_i(1'b0),
    .power_mode_i(pmode),
    .stop_mode_i(stop),
    .compare_match_interrupt_o(irq)
  );

  tmr16_pin_src src_u (
    .clk_i(clk_i),
    .pin_o(pin)
  );

  // Classic single cycle, held until ack is sampled
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    req <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    @(posedge clk_i);
    while (ack !== 1'b1)
      @(posedge clk_i);
    q = rdat;
    req <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rd(input string nm, input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 8'h00);
    chk(nm, e, q);
  endtask

  // Compare load, low half first
  task automatic cmp(input logic [15:0] v);
    bus(1'b1, tmr16_pkg::ADDR_CMP_LO, v[7:0]);
    bus(1'b1, tmr16_pkg::ADDR_CMP_HI, v[15:8]);
  endtask

  task automatic wait_irq(input int k);
    int n;
    n = 0;
    while (irq_n < k && n < 10000)
    begin
      n++;
      @(posedge clk_i);
    end
  endtask

  task automatic reset_values();
    rd("control", tmr16_pkg::ADDR_CTRL, 32'h0);
    rd("compare low", tmr16_pkg::ADDR_CMP_LO, 32'hff);
    rd("count", tmr16_pkg::ADDR_COUNT, 32'h0);
    rd("unmapped", 5'h14, 32'h0);
  endtask

  task automatic pairing();
    bus(1'b1, tmr16_pkg::ADDR_CMP_LO, 8'h05);
    rd("pending", tmr16_pkg::ADDR_STATUS, 32'h1);
    rd("old compare", tmr16_pkg::ADDR_CMP_LO, 32'hff);
    bus(1'b1, tmr16_pkg::ADDR_CMP_HI, 8'h00);
    rd("new compare", tmr16_pkg::ADDR_CMP_LO, 32'h05);
    rd("no pending", tmr16_pkg::ADDR_STATUS, 32'h0);
    bus(1'b1, tmr16_pkg::ADDR_CMP_HI, 8'h12);
    rd("lone high", tmr16_pkg::ADDR_CMP_HI, 32'h0);
  endtask

  // Three ticks of eight cycles per period
  task automatic timer_mode();
    cmp(16'h0003);
    bus(1'b1, tmr16_pkg::ADDR_CTRL, 8'h0c);
    bus(1'b1, tmr16_pkg::ADDR_CTRL, 8'h2c);
    wait_irq(irq_n + 2);
    chk("timer period", 32'd24, irq_t - irq_p);
    bus(1'b1, tmr16_pkg::ADDR_CTRL, 8'h0c);
  endtask

  // Match shows only at the falling pin edge
  task automatic event_mode();
    cmp(16'h0002);
    bus(1'b1, tmr16_pkg::ADDR_CTRL, 8'h1c);
    bus(1'b1, tmr16_pkg::ADDR_CTRL, 8'h3c);
    base = irq_n;
    src_u.level(1'b1, 8);
    src_u.level(1'b0, 8);
    chk("event one", base, irq_n);
    src_u.level(1'b1, 8);
    chk("event rise", base, irq_n);
    src_u.level(1'b0, 8);
    chk("event fall", base + 1, irq_n);
    bus(1'b1, tmr16_pkg::ADDR_CTRL, 8'h00);
  endtask

  // Ticks count only while the pin is high
  task automatic window_mode();
    cmp(16'h0004);
    bus(1'b1, tmr16_pkg::ADDR_CTRL, 8'h0d);
    bus(1'b1, tmr16_pkg::ADDR_CTRL, 8'h2d);
    base = irq_n;
    src_u.level(1'b0, 100);
    chk("window low", base, irq_n);
    src_u.level(1'b1, 70);
    src_u.level(1'b0, 10);
    chk("window high", base + 2, irq_n);
    bus(1'b1, tmr16_pkg::ADDR_CTRL, 8'h00);
  endtask

  task automatic stop_mode();
    bus(1'b1, tmr16_pkg::ADDR_CTRL, 8'hff);
    rd("control bits", tmr16_pkg::ADDR_CTRL, 32'h3d);
    stop <= 1'b1;
    repeat (2) @(posedge clk_i);
    stop <= 1'b0;
    rd("run cleared", tmr16_pkg::ADDR_CTRL, 32'h1d);
  endtask

  // Warm-up in second slow mode: lone high byte, upper five bits match
  task automatic warm_up();
    pmode <= 2'h2;
    bus(1'b1, tmr16_pkg::ADDR_CTRL, 8'h18);
    bus(1'b1, tmr16_pkg::ADDR_CMP_HI, 8'h10);
    rd("warm high", tmr16_pkg::ADDR_CMP_HI, 32'h10);
    bus(1'b1, tmr16_pkg::ADDR_CTRL, 8'h38);
    wait_irq(irq_n + 2);
    chk("warm period", 32'd4096, irq_t - irq_p);
    bus(1'b1, tmr16_pkg::ADDR_CTRL, 8'h18);
    pmode <= 2'h0;
    @(posedge clk_i);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Reset for six cycles, then the scenarios
  initial
  begin
    rst_i = 1'b1;
    req = 1'b0;
    we = 1'b0;
    adr = 5'h00;
    dat = 32'h0;
    stop = 1'b0;
    pmode = 2'h0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    reset_values();
    pairing();
    timer_mode();
    event_mode();
    window_mode();
    stop_mode();
    warm_up();
    print_verdict();
  end
endmodule // test_sixteen_bit_timer_event_window_counter
